/* rtl/fetl_top.sv */
// Contract
// - Five flags, five enables, six cause bits
// - Trap when cause and enable both set
// - Unimplemented cause always traps, no enable
// - Trap before result write or younger completion
// - Untrapped conditions write IEEE default result
// - Completing instructions accumulate flags; traps don't
// - Flags set by hardware, written by software
// - One condition, except inexact with overflow/underflow
// - Untrapped invalid gives quiet NaN
// - Untrapped divide-by-zero gives signed infinity
// - Overflow result follows rounding mode
// - Inexact gives rounded or overflowed result
// - Untrapped underflow gives rounded result
// - Invalid: sNaN, inf minus inf, 0*inf, 0/0, inf/inf
// - Square root of negative is invalid, -0 fine
// - Unfaithful fixed point conversion is invalid
// - Divide-by-zero only for finite nonzero dividend
// - Tininess judged after rounding, unbounded exponent
// - Loss of accuracy means inexact result
// - Untrapped underflow needs tininess and inexact
// - Trapped underflow signalled on tininess alone
// - Rounding codes: nearest, zero, plus, minus
// - Flush select zeroes tiny results, keeping sign
`timescale 1ns/1ps
module fetl_top (
  input  wire logic                CLK_SYS,
  input  wire logic                RESET,
  input  wire logic                PSEL,
  input  wire logic                PENABLE,
  input  wire logic                PWRITE,
  input  wire logic [7:0]          PADDR,
  input  wire logic [31:0]         PWDATA,
  output logic      [31:0]         PRDATA,
  output logic                     PREADY,
  output logic                     PSLVERR,
  input  wire fetl_pkg::fetl_op_s  OP_IN,
  output logic                     OP_READY,
  output fetl_pkg::fetl_res_s      RES_OUT,
  output logic                     TRAP_PENDING
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Operand classification, used for both operands
  function automatic fetl_pkg::fetl_cls_s fp_class(input logic [31:0] v);
    fetl_pkg::fetl_cls_s c;
    c.sign = v[31];
    c.zero = (v[30:0] == 31'h0000_0000);
    c.inf  = (v[30:0] == fetl_pkg::MAG_INF);
    c.nan  = (v[30:23] == 8'hFF) && (v[22:0] != 23'h00_0000);
    c.snan = c.nan && !v[22];
    return c;
  endfunction

  // Register address decode, used by read and write paths
  function automatic logic [1:0] reg_sel(input logic [7:0] a);
    logic [1:0] s;
    s = 2'h0;
    if (a == fetl_pkg::ADDR_CSR)  s = 2'h1;
    if (a == fetl_pkg::ADDR_STAT) s = 2'h2;
    return s;
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [1:0]         rm_r;
  logic               fs_r;
  logic [4:0]         en_r;
  logic [4:0]         flag_r;
  logic [5:0]         cause_r;
  logic               last_trap_r;
  logic [31:0]        prdata_r;
  fetl_pkg::fetl_res_s res_r;

  logic [31:0]        opnd [2];
  fetl_pkg::fetl_cls_s cls [2];

  logic               accept;
  logic               csr_wr;
  logic               arith;
  logic               inv;
  logic               dz;
  logic               div_inf_zero;
  logic               special;
  logic               finite;
  logic               tiny;
  logic               ovf;
  logic               und;
  logic               inx;
  logic [5:0]         cause_new;
  logic               trap_new;
  logic               res_sign;
  logic [31:0]        dflt_word;
  logic [31:0]        rd_mux;

  // ----------------------------------------------------------------
  // Operand classification
  // ----------------------------------------------------------------
  assign opnd[0] = OP_IN.opa;
  assign opnd[1] = OP_IN.opb;

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_cls
      assign cls[g] = fp_class(opnd[g]);
    end
  endgenerate

  // ----------------------------------------------------------------
  // Trap term and acceptance
  // ----------------------------------------------------------------
  // Pure combination of stored bits, so a software write that sets
  // a cause with its enable raises the trap in the next cycle
  assign TRAP_PENDING = (|(cause_r[4:0] & en_r))
                      | cause_r[fetl_pkg::C_UNI];

  // Younger instructions are held off while a trap is pending;
  // software clears enabled causes first to release them
  assign OP_READY = !TRAP_PENDING;
  assign accept   = OP_IN.valid && OP_READY;

  // ----------------------------------------------------------------
  // Invalid and divide-by-zero detection
  // ----------------------------------------------------------------
  always_comb begin
    arith = accept && (OP_IN.kind != fetl_pkg::OP_MOVE);
    inv   = 1'b0;
    dz    = 1'b0;
    div_inf_zero = 1'b0;
    if (arith) begin
      if (cls[0].snan || (cls[1].snan &&
          OP_IN.kind != fetl_pkg::OP_SQRT &&
          OP_IN.kind != fetl_pkg::OP_CVTFX)) begin
        inv = 1'b1;
      end
      case (OP_IN.kind)
        fetl_pkg::OP_ADD, fetl_pkg::OP_SUB: begin
          // Effective subtraction of like infinities
          if (cls[0].inf && cls[1].inf &&
              (cls[0].sign ^ cls[1].sign ^
               (OP_IN.kind == fetl_pkg::OP_SUB))) begin
            inv = 1'b1;
          end
        end
        fetl_pkg::OP_MUL: begin
          if ((cls[0].zero && cls[1].inf) ||
              (cls[0].inf && cls[1].zero)) begin
            inv = 1'b1;
          end
        end
        fetl_pkg::OP_DIV: begin
          if ((cls[0].zero && cls[1].zero) ||
              (cls[0].inf && cls[1].inf)) begin
            inv = 1'b1;
          end
          // Zero divisor with a finite nonzero dividend only
          dz = cls[1].zero && !cls[0].zero &&
               !cls[0].inf && !cls[0].nan;
          div_inf_zero = cls[0].inf && cls[1].zero;
        end
        fetl_pkg::OP_SQRT: begin
          // Negative zero is a legal operand
          if (cls[0].sign && !cls[0].zero && !cls[0].nan) begin
            inv = 1'b1;
          end
        end
        fetl_pkg::OP_CVTFX: begin
          if (OP_IN.cvt_ovf || cls[0].inf || cls[0].nan) begin
            inv = 1'b1;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Overflow, underflow and inexact detection
  // ----------------------------------------------------------------
  // Rounding report is trusted only when no operand is special
  assign special = cls[0].nan || cls[0].inf || cls[1].nan ||
                   cls[1].inf || inv || dz;
  assign finite  = arith && !special &&
                   (OP_IN.kind != fetl_pkg::OP_CVTFX) &&
                   (OP_IN.kind != fetl_pkg::OP_OTHER);

  // Judged on the rounded value with unbounded exponent range
  assign tiny = finite && !OP_IN.rnd_zero &&
                (OP_IN.rnd_exp < fetl_pkg::EXP_MIN);
  assign ovf  = finite &&
                (OP_IN.rnd_exp > fetl_pkg::EXP_MAX);

  // Flushing always loses accuracy, so it counts as inexact
  assign inx = (finite || (OP_IN.kind == fetl_pkg::OP_CVTFX &&
                           arith && !inv)) &&
               (OP_IN.rnd_inexact
                || (ovf && !en_r[fetl_pkg::C_OVF])
                || (fs_r && tiny));

  always_comb begin
    if (en_r[fetl_pkg::C_UND] || fs_r) begin
      und = tiny;
    end else begin
      und = tiny && inx;
    end
  end

  // ----------------------------------------------------------------
  // New cause word
  // ----------------------------------------------------------------
  // Unimplemented outranks all; invalid and divide-by-zero stand
  // alone; only overflow or underflow may pair with inexact
  always_comb begin
    cause_new = 6'h00;
    if (arith && OP_IN.unimpl) begin
      cause_new[fetl_pkg::C_UNI] = 1'b1;
    end else if (inv) begin
      cause_new[fetl_pkg::C_INV] = 1'b1;
    end else if (dz) begin
      cause_new[fetl_pkg::C_DZ] = 1'b1;
    end else begin
      cause_new[fetl_pkg::C_OVF] = ovf;
      cause_new[fetl_pkg::C_UND] = und && !ovf;
      cause_new[fetl_pkg::C_INX] = inx;
    end
  end

  assign trap_new = (|(cause_new[4:0] & en_r))
                  | cause_new[fetl_pkg::C_UNI];

  // ----------------------------------------------------------------
  // Default result
  // ----------------------------------------------------------------
  assign res_sign = (dz || div_inf_zero) ? (cls[0].sign ^ cls[1].sign)
                                         : OP_IN.rnd_word[31];

  fetl_dflt u_dflt (
    .rm       (rm_r),
    .fs       (fs_r),
    .inv      (inv),
    .dz_inf   (dz || div_inf_zero),
    .ovf      (ovf),
    .tiny     (tiny),
    .sign     (res_sign),
    .rnd_word (OP_IN.rnd_word),
    .word     (dflt_word)
  );

  // ----------------------------------------------------------------
  // Completion report
  // ----------------------------------------------------------------
  // A trapping instruction never writes its destination
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      res_r <= '0;
    end else begin
      res_r.valid <= accept;
      res_r.trap  <= accept && trap_new;
      res_r.wr_en <= accept && !trap_new;
      res_r.word  <= accept ? dflt_word : res_r.word;
      res_r.cause <= accept ? cause_new : res_r.cause;
    end
  end

  assign RES_OUT = res_r;

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  // Zero wait states; read data is captured in the setup phase
  assign PREADY  = 1'b1;
  assign PSLVERR = PSEL && PENABLE && (reg_sel(PADDR) == 2'h0);
  assign PRDATA  = prdata_r;
  assign csr_wr  = PSEL && PENABLE && PWRITE &&
                   (reg_sel(PADDR) == 2'h1);

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (reg_sel(PADDR))
      2'h1: begin
        rd_mux[fetl_pkg::CSR_RM_LSB +: 2]       = rm_r;
        rd_mux[fetl_pkg::CSR_FS_BIT]            = fs_r;
        rd_mux[fetl_pkg::CSR_FLAG_LSB +: 5]     = flag_r;
        rd_mux[fetl_pkg::CSR_EN_LSB +: 5]       = en_r;
        rd_mux[fetl_pkg::CSR_CAUSE_LSB +: 6]    = cause_r;
      end
      2'h2: begin
        rd_mux[fetl_pkg::STAT_PEND_BIT] = TRAP_PENDING;
        rd_mux[fetl_pkg::STAT_LAST_BIT] = last_trap_r;
      end
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // Read data register
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      prdata_r <= 32'h0000_0000;
    end else if (PSEL && !PENABLE && !PWRITE) begin
      prdata_r <= rd_mux;
    end
  end

  // ----------------------------------------------------------------
  // Control fields: rounding mode, flush select, enables
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      rm_r <= fetl_pkg::CSR_RESET[fetl_pkg::CSR_RM_LSB +: 2];
      fs_r <= fetl_pkg::CSR_RESET[fetl_pkg::CSR_FS_BIT];
      en_r <= fetl_pkg::CSR_RESET[fetl_pkg::CSR_EN_LSB +: 5];
    end else if (csr_wr) begin
      rm_r <= PWDATA[fetl_pkg::CSR_RM_LSB +: 2];
      fs_r <= PWDATA[fetl_pkg::CSR_FS_BIT];
      en_r <= PWDATA[fetl_pkg::CSR_EN_LSB +: 5];
    end
  end

  // ----------------------------------------------------------------
  // Cause field
  // ----------------------------------------------------------------
  // An arithmetic op (any kind but a move) in the same cycle as a
  // software write wins, so the newest hardware report is never lost
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      cause_r <= fetl_pkg::CSR_RESET[fetl_pkg::CSR_CAUSE_LSB +: 6];
    end else if (arith) begin
      cause_r <= cause_new;
    end else if (csr_wr) begin
      cause_r <= PWDATA[fetl_pkg::CSR_CAUSE_LSB +: 6];
    end
  end

  // ----------------------------------------------------------------
  // Flag field
  // ----------------------------------------------------------------
  // Sticky: completion ORs in, software write may clear; a set in
  // the same cycle as a clearing write survives
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      flag_r <= fetl_pkg::CSR_RESET[fetl_pkg::CSR_FLAG_LSB +: 5];
    end else begin
      flag_r <= (csr_wr ? PWDATA[fetl_pkg::CSR_FLAG_LSB +: 5]
                        : flag_r)
              | ((arith && !trap_new) ? cause_new[4:0]
                                      : 5'h00);
    end
  end

  // ----------------------------------------------------------------
  // Last operation status
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      last_trap_r <= 1'b0;
    end else if (accept) begin
      last_trap_r <= trap_new;
    end
  end

endmodule // fetl_top

/* rtl/fetl_pkg.sv */
package fetl_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CSR  = 8'h00; // fp_control_status_reg
  localparam logic [7:0] ADDR_STAT = 8'h04; // Trap status, read only

  // Control/status field positions
  localparam int CSR_RM_LSB    = 0;  // Rounding mode, 2 bits
  localparam int CSR_FS_BIT    = 2;  // flush_zero_select
  localparam int CSR_FLAG_LSB  = 3;  // Flags, 5 bits
  localparam int CSR_EN_LSB    = 8;  // Enables, 5 bits
  localparam int CSR_CAUSE_LSB = 13; // Cause, 6 bits
  localparam int STAT_PEND_BIT = 0;  // Trap pending
  localparam int STAT_LAST_BIT = 1;  // Last operation trapped

  localparam logic [31:0] CSR_RESET = 32'h0000_0000;

  // Condition bit indices inside cause, enable and flag groups
  localparam int C_INX = 0;
  localparam int C_UND = 1;
  localparam int C_OVF = 2;
  localparam int C_DZ  = 3;
  localparam int C_INV = 4;
  localparam int C_UNI = 5;
  localparam int NCOND = 5;

  // Rounding mode codes
  localparam logic [1:0] RND_NEAREST_EVEN = 2'h0;
  localparam logic [1:0] RND_TO_ZERO      = 2'h1;
  localparam logic [1:0] RND_TO_PLUS_INF  = 2'h2;
  localparam logic [1:0] RND_TO_MINUS_INF = 2'h3;

  // Single precision constants
  localparam logic signed [9:0] EXP_MIN  = -10'sd126;
  localparam logic signed [9:0] EXP_MAX  = 10'sd127;
  localparam logic [30:0]       MAG_INF  = 31'h7F80_0000;
  localparam logic [30:0]       MAG_MAXF = 31'h7F7F_FFFF;
  localparam logic [31:0]       QNAN     = 32'h7FC0_0000;

  typedef enum logic [2:0] {
    OP_ADD   = 3'h0,
    OP_SUB   = 3'h1,
    OP_MUL   = 3'h2,
    OP_DIV   = 3'h3,
    OP_SQRT  = 3'h4,
    OP_CVTFX = 3'h5,
    OP_MOVE  = 3'h6, // fp_plain_move
    OP_OTHER = 3'h7
  } fetl_kind_e;

  // Operation report from the arithmetic unit
  typedef struct packed {
    logic              valid;
    fetl_kind_e        kind;
    logic [31:0]       opa;
    logic [31:0]       opb;
    logic              unimpl;      // Hardware cannot do it
    logic              cvt_ovf;     // Fixed point target overflow
    logic [31:0]       rnd_word;    // Rounded, bounded result
    logic signed [9:0] rnd_exp;     // Exponent, unbounded range
    logic              rnd_zero;    // Rounded result is zero
    logic              rnd_inexact; // Differs from exact result
  } fetl_op_s;

  // Completion report toward the pipeline
  typedef struct packed {
    logic        valid;
    logic        wr_en;
    logic        trap;
    logic [31:0] word;
    logic [5:0]  cause;
  } fetl_res_s;

  typedef struct packed {
    logic sign;
    logic zero;
    logic inf;
    logic nan;
    logic snan;
  } fetl_cls_s;

endpackage

/* rtl/fetl_dflt.sv */
`timescale 1ns/1ps
module fetl_dflt (
  input  wire logic [1:0]  rm,
  input  wire logic        fs,
  input  wire logic        inv,
  input  wire logic        dz_inf,
  input  wire logic        ovf,
  input  wire logic        tiny,
  input  wire logic        sign,
  input  wire logic [31:0] rnd_word,
  output logic      [31:0] word
);

  // ----------------------------------------------------------------
  // Default result selection
  // ----------------------------------------------------------------
  // Only one special case can apply; invalid is checked first
  always_comb begin
    word = rnd_word;
    if (inv) begin
      word = fetl_pkg::QNAN;
    end else if (dz_inf) begin
      word = {sign, fetl_pkg::MAG_INF};
    end else if (ovf) begin
      // Overflowed value also serves an untrapped inexact
      case (rm)
        fetl_pkg::RND_NEAREST_EVEN: word = {sign, fetl_pkg::MAG_INF};
        fetl_pkg::RND_TO_ZERO:      word = {sign, fetl_pkg::MAG_MAXF};
        fetl_pkg::RND_TO_PLUS_INF:
          word = sign ? {1'b1, fetl_pkg::MAG_MAXF}
                      : {1'b0, fetl_pkg::MAG_INF};
        fetl_pkg::RND_TO_MINUS_INF:
          word = sign ? {1'b1, fetl_pkg::MAG_INF}
                      : {1'b0, fetl_pkg::MAG_MAXF};
        default:                    word = {sign, fetl_pkg::MAG_INF};
      endcase
    end else if (fs && tiny) begin
      word = {sign, 31'h0000_0000};
    end
  end

endmodule // fetl_dflt

/* test/fetl_top_properties.sv */
`timescale 1ns/1ps
// --------
// Port checker
// --------
module fetl_top_properties (
  input wire logic                CLK_SYS,
  input wire logic                RESET,
  input wire logic                PSEL,
  input wire logic                PENABLE,
  input wire logic                PWRITE,
  input wire fetl_pkg::fetl_op_s  OP_IN,
  input wire logic                OP_READY,
  input wire fetl_pkg::fetl_res_s RES_OUT,
  input wire logic                TRAP_PENDING
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RESET);

  // Ops are refused exactly while a trap waits
  a_ready_refuse: assert property (OP_READY == !TRAP_PENDING)
    else $error("op ready disagrees with trap pending");
  a_result_next: assert property (
    OP_IN.valid && OP_READY |=> RES_OUT.valid)
    else $error("accepted op gave no result");
  a_no_stray: assert property (
    !(OP_IN.valid && OP_READY) |=> !RES_OUT.valid)
    else $error("result without accepted op");
  // Cause stands until the next accepted op replaces it
  a_cause_holds: assert property (
    !(OP_IN.valid && OP_READY) |=> $stable(RES_OUT.cause))
    else $error("cause changed without op");
  a_trap_nowrite: assert property (
    RES_OUT.valid |-> RES_OUT.trap != RES_OUT.wr_en)
    else $error("trap and write not exclusive");
  a_unimpl_trap: assert property (
    RES_OUT.valid && RES_OUT.cause[5] |-> RES_OUT.trap && TRAP_PENDING)
    else $error("unimplemented op did not trap");
  a_one_cond: assert property (
    RES_OUT.valid |-> $onehot0(RES_OUT.cause[5:1]))
    else $error("more than one condition raised");
  a_dz_infinity: assert property (
    RES_OUT.wr_en && RES_OUT.cause[3]
      |-> RES_OUT.word[30:0] == fetl_pkg::MAG_INF)
    else $error("divide by zero result not infinity");
  a_inv_qnan: assert property (
    RES_OUT.wr_en && RES_OUT.cause[4] |-> RES_OUT.word == fetl_pkg::QNAN)
    else $error("invalid result not quiet NaN");
  // Only a register write may retire a pending trap
  a_clear_by_write: assert property (
    $fell(TRAP_PENDING) |-> $past(PSEL && PENABLE && PWRITE))
    else $error("trap cleared without register write");
endmodule // fetl_top_properties

/* test/fetl_pipe_model.sv */
`timescale 1ns/1ps
// --------
// Core pipeline stand-in
// --------
module fetl_pipe_model (
  input  wire logic                clk,
  input  wire logic                rst,
  input  wire logic                go,
  input  wire fetl_pkg::fetl_op_s  req,
  input  wire logic                OP_READY,
  input  wire fetl_pkg::fetl_res_s RES_OUT,
  output fetl_pkg::fetl_op_s       OP_IN,
  output logic                     got,
  output fetl_pkg::fetl_res_s      res
);
  // Issue: hold the op until taken, so a refused op is retried
  always_ff @(posedge clk) begin
    if (rst || (OP_IN.valid && OP_READY)) begin
      OP_IN <= '0;
    end else if (go) begin
      OP_IN <= req;
    end
  end

  // Writeback: capture each completion, flag it for one cycle
  always_ff @(posedge clk) begin
    got <= RES_OUT.valid;
    if (RES_OUT.valid) begin
      res <= RES_OUT;
    end
  end
endmodule // fetl_pipe_model

/* test/tb_fetl_top.sv */
`timescale 1ns/1ps
// --------
// Bench top
// --------
module tb_fetl_top;
  localparam logic [2:0]  k_add = fetl_pkg::OP_ADD;
  localparam logic [2:0]  k_sub = fetl_pkg::OP_SUB;
  localparam logic [2:0]  k_mul = fetl_pkg::OP_MUL;
  localparam logic [2:0]  k_div = fetl_pkg::OP_DIV;
  localparam logic [2:0]  k_sqr = fetl_pkg::OP_SQRT;
  localparam logic [2:0]  k_cvt = fetl_pkg::OP_CVTFX;
  localparam logic [2:0]  k_mov = fetl_pkg::OP_MOVE;
  localparam logic [7:0]  a_csr = fetl_pkg::ADDR_CSR;
  localparam logic [7:0]  a_st  = fetl_pkg::ADDR_STAT;
  localparam logic [31:0] one   = 32'h3F80_0000;
  localparam logic [31:0] mone  = 32'hBF80_0000;
  localparam logic [31:0] two   = 32'h4000_0000;
  localparam logic [31:0] zro   = 32'h0000_0000;
  localparam logic [31:0] pinf  = 32'h7F80_0000;
  localparam logic [31:0] ninf  = 32'hFF80_0000;
  localparam logic [31:0] snan  = 32'h7F80_0001;
  localparam logic [31:0] tiny  = 32'h0040_0000;
  localparam logic [31:0] qn    = fetl_pkg::QNAN;
  localparam logic [31:0] ovp [4] = '{pinf, 32'h7F7FFFFF, pinf, 32'h7F7FFFFF};
  localparam logic [31:0] ovn [4] = '{ninf, 32'hFF7FFFFF, 32'hFF7FFFFF, ninf};

  logic                clk, rst, psel, penable, pwrite, pready, pslverr;
  logic                go, got, op_ready, trap_pend;
  logic [7:0]          paddr;
  logic [31:0]         pwdata, prdata;
  fetl_pkg::fetl_op_s  req, op_in;
  fetl_pkg::fetl_res_s res_out, res;
  int                  failures, tests_run;

  fetl_top u_fetl_top (.CLK_SYS(clk), .RESET(rst), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .OP_IN(op_in),
    .OP_READY(op_ready), .RES_OUT(res_out), .TRAP_PENDING(trap_pend));
  fetl_pipe_model u_fetl_pipe_model (.clk(clk), .rst(rst), .go(go),
    .req(req), .OP_READY(op_ready), .RES_OUT(res_out), .OP_IN(op_in),
    .got(got), .res(res));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic test_done();
    $display("Checks %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    tests_run++;
    if (g !== x) begin
      failures++;
      $display("Error t=%0t got %h expected %h", $time, g, x);
    end
  endtask

  // One APB transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] ad,
                     input logic [31:0] d, input logic [31:0] x,
                     input logic xe);
    int n;
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= ad;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      failures++;
      $display("Error t=%0t bus answer timed out", $time);
      test_done();
    end
    if (!w) chk(prdata, x);
    chk({31'h0, pslverr}, {31'h0, xe});
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    apb(1'b1, ad, d, 32'h0, 1'b0);
  endtask

  task automatic rd(input logic [7:0] ad, input logic [31:0] x);
    apb(1'b0, ad, 32'h0, x, 1'b0);
  endtask

  // f holds unimplemented, convert overflow, zero, inexact
  task automatic send(input logic [2:0] k, input logic [31:0] a, b, w,
                      input logic [9:0] e, input logic [3:0] f);
    req <= '{valid:1'b1, kind:fetl_pkg::fetl_kind_e'(k), opa:a, opb:b,
             unimpl:f[3], cvt_ovf:f[2], rnd_word:w, rnd_exp:e,
             rnd_zero:f[1], rnd_inexact:f[0]};
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
  endtask

  // xc holds trap then the six cause bits
  task automatic recv(input logic [6:0] xc, input logic [31:0] xw);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (got !== 1'b1 && n < 20);
    if (got !== 1'b1) begin
      failures++;
      $display("Error t=%0t result timed out", $time);
      test_done();
    end
    chk({25'h0, res.trap, res.cause}, {25'h0, xc});
    chk({31'h0, res.wr_en}, {31'h0, !xc[6]});
    if (!xc[6]) chk(res.word, xw);
  endtask

  task automatic op(input logic [2:0] k, input logic [31:0] a, b, w,
                    input logic [9:0] e, input logic [3:0] f,
                    input logic [6:0] xc, input logic [31:0] xw);
    send(k, a, b, w, e, f);
    recv(xc, xw);
  endtask

  // --------
  // Main sequence
  // --------
  initial begin
    {rst, psel, penable, pwrite, go} = 5'h10;
    paddr = 8'h00;
    pwdata = 32'h0;
    req = '0;
    failures = 0;
    tests_run = 0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rd(a_csr, 32'h0);
    rd(a_st, 32'h0);
    apb(1'b0, 8'h10, 32'h0, 32'h0, 1'b1);
    $display("test reset done");
    op(k_add, pinf, ninf, one, 10'h000, 4'h0, 7'h10, qn);
    op(k_sub, pinf, pinf, one, 10'h000, 4'h0, 7'h10, qn);
    op(k_mul, zro, ninf, one, 10'h000, 4'h0, 7'h10, qn);
    op(k_div, pinf, ninf, one, 10'h000, 4'h0, 7'h10, qn);
    op(k_add, snan, one, one, 10'h000, 4'h0, 7'h10, qn);
    op(3'h7, one, snan, one, 10'h000, 4'h0, 7'h10, qn);
    op(k_mov, snan, one, snan, 10'h000, 4'h0, 7'h00, snan);
    op(k_sqr, mone, zro, one, 10'h000, 4'h0, 7'h10, qn);
    op(k_sqr, ninf ^ pinf, zro, zro, 10'h000, 4'h2, 7'h00, zro);
    op(k_cvt, one, zro, one, 10'h000, 4'h4, 7'h10, qn);
    op(k_div, ninf, zro, one, 10'h000, 4'h0, 7'h00, ninf);
    op(k_div, mone, zro, one, 10'h000, 4'h0, 7'h08, ninf);
    $display("test conditions done");
    for (int m = 0; m < 4; m++) begin
      wr(a_csr, 32'(m));
      op(k_mul, one, one, pinf, 10'h080, 4'h1, 7'h05, ovp[m]);
      op(k_mul, mone, one, ninf, 10'h080, 4'h0, 7'h05, ovn[m]);
    end
    $display("test overflow done");
    wr(a_csr, 32'h0);
    op(k_mul, one, one, tiny, 10'h381, 4'h1, 7'h03, tiny);
    op(k_mul, one, one, tiny, 10'h381, 4'h0, 7'h00, tiny);
    op(k_mul, one, one, one, 10'h382, 4'h1, 7'h01, one);
    wr(a_csr, 32'h4);
    op(k_mul, mone, one, 32'h8040_0000, 10'h381, 4'h0, 7'h03,
       32'h8000_0000);
    $display("test underflow done");
    wr(a_csr, 32'h0);
    op(k_div, one, zro, one, 10'h000, 4'h0, 7'h08, pinf);
    op(k_div, zro, zro, one, 10'h000, 4'h0, 7'h10, qn);
    rd(a_csr, 32'h0002_00C0);
    op(k_add, one, one, two, 10'h001, 4'h0, 7'h00, two);
    rd(a_csr, 32'h0000_00C0);
    wr(a_csr, 32'h0);
    rd(a_csr, 32'h0);
    $display("test flags done");
    wr(a_csr, 32'h0000_0200);
    op(k_mul, one, one, tiny, 10'h381, 4'h0, 7'h42, tiny);
    chk({31'h0, trap_pend}, 32'h1);
    rd(a_csr, 32'h0000_4200);
    rd(a_st, 32'h3);
    // A queued op must wait out the trap, then retire normally
    send(k_add, one, one, two, 10'h001, 4'h0);
    repeat (4) @(posedge clk);
    chk({31'h0, got}, 32'h0);
    wr(a_csr, 32'h0);
    recv(7'h00, two);
    wr(a_csr, 32'h0002_1000);
    chk({31'h0, trap_pend}, 32'h1);
    wr(a_csr, 32'h0);
    chk({31'h0, trap_pend}, 32'h0);
    op(k_add, one, one, two, 10'h001, 4'h8, 7'h60, two);
    wr(a_csr, 32'h0);
    rd(a_st, 32'h2);
    $display("test traps done");
    test_done();
  end
endmodule // tb_fetl_top

bind fetl_top fetl_top_properties u_fetl_top_properties (
  .CLK_SYS(CLK_SYS), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .OP_IN(OP_IN), .OP_READY(OP_READY),
  .RES_OUT(RES_OUT), .TRAP_PENDING(TRAP_PENDING));
